//--- core/stcd_pkg.sv
// Constants and types for the sensor trim command decoder
package stcd_pkg;
  localparam logic [3:0] FS_DATA0 = 4'h0;
  localparam logic [3:0] FS_DATA3 = 4'h3;
  localparam logic [3:0] FS_SELECT = 4'h6;
  localparam logic [3:0] FS_ADDR_MID = 4'h7;
  localparam logic [3:0] FS_POINTER = 4'h8;
  localparam logic [3:0] FS_COMMAND = 4'h9;
  localparam logic [3:0] FS_HOLD = 4'ha;
  localparam logic [3:0] FS_NODE = 4'hb;
  localparam logic [3:0] CAL_COUNT = 4'h5;
  localparam logic [7:0] LINK_PATTERN = 8'hca;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam int NVM_BYTES = 768;
  localparam int PAGE_BYTES = 64;
  localparam int PAGES = 12;
  localparam logic [3:0] HOLD_FOREVER = 4'hf;
  localparam int BITS_PER_BYTE = 8;
  localparam int LOCKOUT_BYTES = 32769;
  localparam logic [15:0] CAL_RESET = 16'h0000;
  typedef enum logic [3:0] {
    STCD_LOAD_CAL = 4'h0,
    STCD_NVM_PROGRAM = 4'h1,
    STCD_NVM_ERASE = 4'h2,
    STCD_READ_CAL = 4'h3,
    STCD_READ_NVM = 4'h4,
    STCD_READBACK = 4'h5,
    STCD_ANALOG_PROBE = 4'h6,
    STCD_SECTOR_CLEAR = 4'h7
  } stcd_cmd_t;
  typedef enum logic [1:0] {
    STCD_IDLE = 2'b00,
    STCD_PROBE = 2'b01,
    STCD_ERASING = 2'b11
  } stcd_state_t;
  typedef struct packed {
    logic [3:0] field;
    logic [3:0] nibble;
  } stcd_write_t;
endpackage : stcd_pkg

//--- core/stcd_decoder.sv
// Command decoder, interface fields, calibration bank and NVM array
`timescale 1ns/1ps
module stcd_decoder #(
  parameter int BIT_CYCLES = 4,
  parameter int LOCKOUT = stcd_pkg::LOCKOUT_BYTES
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_valid,
  input wire stcd_pkg::stcd_write_t wr,
  input wire logic [7:0] temp_index,
  input wire logic [7:0] measured_bit_period,
  input wire logic [7:0] memory_test_byte,
  output logic [7:0] readback_byte,
  output logic readback_valid,
  output logic analog_drive,
  output logic [3:0] analog_node_select,
  output logic busy,
  output logic [15:0] calibration_config,
  output logic [15:0] offset_trim_dac,
  output logic [15:0] offset_tempco_dac,
  output logic [15:0] span_trim_dac,
  output logic [15:0] span_tempco_dac
);
  logic rst_meta;
  logic rst_sync;
  logic [15:0] data_hold_word;
  logic [3:0] calib_reg_select;
  logic [3:0] nvm_addr_mid;
  logic [3:0] readback_pointer;
  logic [3:0] command_nibble;
  logic [3:0] analog_hold_code;
  logic [7:0] nvm_data_byte;
  logic [9:0] nvm_byte_address;
  logic [7:0] nvm [stcd_pkg::NVM_BYTES];
  logic [15:0] cal [5];
  stcd_pkg::stcd_state_t state;
  logic [9:0] erase_cycles;
  logic [6:0] erase_len;
  logic [9:0] erase_ptr;
  logic [15:0] bit_cnt;
  logic [2:0] bitpos;
  logic [15:0] bytes_left;
  logic forever_mode;
  logic start;
  logic byte_tick;
  logic [7:0] sel_byte;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // Pointer low bits double as address 9:8
  assign nvm_byte_address = {readback_pointer[1:0], nvm_addr_mid,
    calib_reg_select};
  // Writes are dropped while busy, so fields stay as the run began
  // Reserved codes match no branch below and change only command_nibble
  assign start = wr_valid && !busy
    && wr.field == stcd_pkg::FS_COMMAND;

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      calib_reg_select <= 4'h0;
      nvm_addr_mid <= 4'h0;
      readback_pointer <= 4'h0;
      command_nibble <= 4'h0;
      analog_hold_code <= 4'h0;
      analog_node_select <= 4'h0;
    end
    else if (wr_valid && !busy)
    begin
      if (wr.field == stcd_pkg::FS_SELECT)
        calib_reg_select <= wr.nibble;
      else if (wr.field == stcd_pkg::FS_ADDR_MID)
        nvm_addr_mid <= wr.nibble;
      else if (wr.field == stcd_pkg::FS_POINTER)
        readback_pointer <= wr.nibble;
      else if (wr.field == stcd_pkg::FS_COMMAND)
        command_nibble <= wr.nibble;
      else if (wr.field == stcd_pkg::FS_HOLD)
        analog_hold_code <= wr.nibble;
      else if (wr.field == stcd_pkg::FS_NODE)
        analog_node_select <= wr.nibble;
    end
  end

  always_comb
  begin
    case (readback_pointer)
      4'h0: sel_byte = data_hold_word[7:0];
      4'h1: sel_byte = data_hold_word[15:8];
      4'h2: sel_byte = {nvm_addr_mid, calib_reg_select};
      4'h3: sel_byte = {command_nibble, readback_pointer};
      4'h4: sel_byte = {analog_node_select, analog_hold_code};
      4'h5: sel_byte = nvm_byte_address[7:0];
      4'h6: sel_byte = nvm_data_byte;
      4'h7: sel_byte = temp_index;
      4'h8: sel_byte = measured_bit_period;
      4'h9: sel_byte = memory_test_byte;
      default: sel_byte = stcd_pkg::LINK_PATTERN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      data_hold_word <= 16'h0000;
    else if (start && wr.nibble == stcd_pkg::STCD_READ_CAL
             && calib_reg_select < stcd_pkg::CAL_COUNT)
      data_hold_word <= cal[calib_reg_select[2:0]];
    else if (start && wr.nibble == stcd_pkg::STCD_READ_NVM)
      data_hold_word[7:0] <= nvm[nvm_byte_address];
    else if (wr_valid && !busy && wr.field <= stcd_pkg::FS_DATA3)
      data_hold_word[wr.field[1:0]*4 +: 4] <= wr.nibble;
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      for (int i = 0; i < 5; i++)
        cal[i] <= stcd_pkg::CAL_RESET;
    end
    else if (start && wr.nibble == stcd_pkg::STCD_LOAD_CAL
             && calib_reg_select < stcd_pkg::CAL_COUNT)
      cal[calib_reg_select[2:0]] <= data_hold_word;
  end
  assign calibration_config = cal[0];
  assign offset_trim_dac = cal[1];
  assign offset_tempco_dac = cal[2];
  assign span_trim_dac = cal[3];
  assign span_tempco_dac = cal[4];

  // Erase walks one byte per cycle rather than a wide clear port
  always_ff @(posedge clk)
  begin
    if (start && wr.nibble == stcd_pkg::STCD_NVM_PROGRAM
        && nvm_byte_address < 10'(stcd_pkg::NVM_BYTES))
      nvm[nvm_byte_address] <= data_hold_word[7:0];
    else if (state == stcd_pkg::STCD_ERASING)
      nvm[erase_ptr] <= stcd_pkg::ERASED_BYTE;
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      nvm_data_byte <= 8'h00;
    else if (start && wr.nibble == stcd_pkg::STCD_READ_NVM)
      nvm_data_byte <= nvm[nvm_byte_address];
  end

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      readback_byte <= 8'h00;
      readback_valid <= 1'b0;
    end
    else
    begin
      readback_valid <= start && wr.nibble == stcd_pkg::STCD_READBACK;
      if (start && wr.nibble == stcd_pkg::STCD_READBACK)
        readback_byte <= sel_byte;
    end
  end

  assign byte_tick = bit_cnt == 16'(BIT_CYCLES - 1) && bitpos == 3'h7;

  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
    begin
      state <= stcd_pkg::STCD_IDLE;
      erase_ptr <= 10'h000;
      busy <= 1'b0;
      erase_len <= 7'h00;
      bit_cnt <= 16'h0000;
      bitpos <= 3'h0;
      bytes_left <= 16'h0000;
      forever_mode <= 1'b0;
      analog_drive <= 1'b0;
    end
    else
    begin
      case (state)
        stcd_pkg::STCD_IDLE:
        begin
          if (start && wr.nibble == stcd_pkg::STCD_NVM_ERASE)
          begin
            state <= stcd_pkg::STCD_ERASING;
            busy <= 1'b1;
            erase_ptr <= 10'h000;
            erase_len <= 7'h00;
          end
          else if (start && wr.nibble == stcd_pkg::STCD_SECTOR_CLEAR
                   && nvm_byte_address[9:6] < 4'(stcd_pkg::PAGES))
          begin
            state <= stcd_pkg::STCD_ERASING;
            busy <= 1'b1;
            erase_ptr <= {nvm_byte_address[9:6], 6'h00};
            erase_len <= 7'(stcd_pkg::PAGE_BYTES);
          end
          else if (start && wr.nibble == stcd_pkg::STCD_ANALOG_PROBE)
          begin
            state <= stcd_pkg::STCD_PROBE;
            busy <= 1'b1;
            analog_drive <= 1'b1;
            bit_cnt <= 16'h0000;
            bitpos <= 3'h0;
            forever_mode <= analog_hold_code == stcd_pkg::HOLD_FOREVER;
            if (analog_hold_code == stcd_pkg::HOLD_FOREVER)
              bytes_left <= 16'(LOCKOUT);
            else
              bytes_left <= (16'h0001 << analog_hold_code) + 16'h0001;
          end
        end
        stcd_pkg::STCD_ERASING:
        begin
          erase_ptr <= erase_ptr + 10'h001;
          if ((erase_len == 7'h00
               && erase_ptr == 10'(stcd_pkg::NVM_BYTES - 1))
              || (erase_len != 7'h00 && erase_ptr[5:0] == 6'h3f))
          begin
            state <= stcd_pkg::STCD_IDLE;
            busy <= 1'b0;
          end
        end
        stcd_pkg::STCD_PROBE:
        begin
          bit_cnt <= bit_cnt == 16'(BIT_CYCLES - 1) ? 16'h0000
                     : bit_cnt + 16'h0001;
          if (bit_cnt == 16'(BIT_CYCLES - 1))
            bitpos <= bitpos + 3'h1;
          if (byte_tick)
          begin
            bytes_left <= bytes_left - 16'h0001;
            if (bytes_left == 16'h0001)
            begin
              state <= stcd_pkg::STCD_IDLE;
              busy <= 1'b0;
              analog_drive <= forever_mode;
            end
          end
        end
        default:
        begin
          state <= stcd_pkg::STCD_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
  // Busy follows every state move so the port comes from a flop

  // Counter stands in for a long repetition in the erase check
  always_ff @(posedge clk or negedge rst_sync)
  begin
    if (!rst_sync)
      erase_cycles <= 10'h000;
    else if (state == stcd_pkg::STCD_ERASING)
      erase_cycles <= erase_cycles + 10'h001;
    else
      erase_cycles <= 10'h000;
  end

  stcd_state_hold_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == stcd_pkg::STCD_ANALOG_PROBE |=> analog_drive)
    else $error("probe did not drive");
  stcd_busy_drop_a: assert property (@(posedge clk) disable iff (!rst_sync)
    busy && wr_valid |=> $stable(command_nibble))
    else $error("command taken while busy");
  stcd_readback_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == stcd_pkg::STCD_READBACK && readback_pointer >= 4'ha
    |=> readback_valid && readback_byte == 8'hca)
    else $error("bad link pattern");
  stcd_reserved_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble[3] |=> !busy && $stable(calibration_config))
    else $error("reserved code acted");
  stcd_load_cal_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == 4'h0 && calib_reg_select == 4'h1
    |=> offset_trim_dac == $past(data_hold_word))
    else $error("load failed");
  stcd_hold_short_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == 4'h6 && analog_hold_code == 4'h0
    |=> busy [*8])
    else $error("probe ended early");
  stcd_erase_end_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == 4'h7 && nvm_byte_address[9:6] < 4'hc
    |=> busy [*8] ##[1:60] !busy)
    else $error("page erase timing");
  stcd_fields_a: assert property (@(posedge clk) disable iff (!rst_sync)
    wr_valid && !busy && wr.field == 4'h8
    |=> readback_pointer == $past(wr.nibble))
    else $error("pointer write lost");
  stcd_probe_c: cover property (@(posedge clk) start && wr.nibble == 4'h6);
  stcd_erase_c: cover property (@(posedge clk) start && wr.nibble == 4'h2);
  stcd_back_c: cover property (@(posedge clk) readback_valid);
  stcd_page_c: cover property (@(posedge clk) start && wr.nibble == 4'h7);
  stcd_forever_c: cover property (@(posedge clk) $fell(busy) && forever_mode);

  stcd_busy_gate_a: assert property (@(posedge clk) disable iff (!rst_sync)
    busy && wr_valid && wr.field == stcd_pkg::FS_COMMAND
    |=> $stable(data_hold_word))
    else $error("command acted while busy");
  stcd_erase_len_a: assert property (@(posedge clk) disable iff (!rst_sync)
    $fell(busy) && $past(state) == stcd_pkg::STCD_ERASING
    |-> $past(erase_cycles) == 10'h2ff
    || $past(erase_cycles) == 10'h03f)
    else $error("erase length wrong");
  stcd_probe_end_a: assert property (@(posedge clk) disable iff (!rst_sync)
    $fell(analog_drive) |-> $past(byte_tick)
    && $past(bytes_left) == 16'h0001)
    else $error("probe ended off count");
  stcd_page_bound_a: assert property (@(posedge clk) disable iff (!rst_sync)
    state == stcd_pkg::STCD_ERASING |-> erase_ptr < 10'h300)
    else $error("erase left the array");
  stcd_nvm_prog_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == stcd_pkg::STCD_NVM_PROGRAM
    && nvm_byte_address < 10'h300
    |=> nvm[$past(nvm_byte_address)] == $past(data_hold_word[7:0]))
    else $error("program lost");
  stcd_erase_val_a: assert property (@(posedge clk) disable iff (!rst_sync)
    state == stcd_pkg::STCD_ERASING
    |=> nvm[$past(erase_ptr)] == stcd_pkg::ERASED_BYTE)
    else $error("byte not erased");
  stcd_read_nvm_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == stcd_pkg::STCD_READ_NVM
    && nvm_byte_address < 10'h300
    |=> data_hold_word[7:0] == nvm[$past(nvm_byte_address)])
    else $error("nvm read lost");
  stcd_read_cal_a: assert property (@(posedge clk) disable iff (!rst_sync)
    start && wr.nibble == stcd_pkg::STCD_READ_CAL
    && calib_reg_select < 4'h5
    |=> data_hold_word == cal[$past(calib_reg_select[2:0])])
    else $error("calibration read lost");
  stcd_forever_a: assert property (@(posedge clk) disable iff (!rst_sync)
    $fell(busy) && forever_mode |-> analog_drive)
    else $error("forever drive dropped");
  stcd_node_a: assert property (@(posedge clk) disable iff (!rst_sync)
    wr_valid && !busy && wr.field == stcd_pkg::FS_NODE
    |=> analog_node_select == $past(wr.nibble))
    else $error("node write lost");
endmodule : stcd_decoder

//--- verif/stcd_host.sv
// Calibration host model issuing interface field writes
`timescale 1ns/1ps
module stcd_host (
  input wire logic clk,
  input wire logic busy,
  output logic wr_valid,
  output stcd_pkg::stcd_write_t wr
);
  initial
  begin
    wr_valid = 1'b0;
    wr = '0;
  end
  // Waits out busy unless told to intrude on purpose
  task automatic put(input logic [3:0] f, input logic [3:0] n,
                     input bit wait_idle = 1'b1);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    while (wait_idle && busy === 1'b1 && k < 2000)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    wr_valid = 1'b1;
    wr = '{field: f, nibble: n};
    @(posedge clk);
    #1;
    wr_valid = 1'b0;
    // Idle bus changes so stale data cannot pass
    wr = ~wr;
  endtask : put
endmodule : stcd_host

//--- verif/testbench.sv
// Self-checking bench for the sensor trim command decoder
`timescale 1ns/1ps
module testbench;
  localparam int BC = 2;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr_valid, readback_valid, analog_drive, busy;
  stcd_pkg::stcd_write_t wr;
  logic [7:0] readback_byte, b;
  logic [3:0] node;
  logic [15:0] ev;
  logic [15:0] cal [5];
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int drv = 0;
  typedef struct {logic [3:0] ptr; logic [7:0] exp;} stcd_row_t;
  stcd_row_t rows [15] = '{'{4'h0, 8'he4}, '{4'h1, 8'hb7}, '{4'h2, 8'h93},
    '{4'h3, 8'h53}, '{4'h4, 8'hc2}, '{4'h5, 8'h93}, '{4'h7, 8'h41},
    '{4'h8, 8'h37}, '{4'h9, 8'h9d}, '{4'ha, 8'hca}, '{4'hb, 8'hca},
    '{4'hc, 8'hca}, '{4'hd, 8'hca}, '{4'he, 8'hca}, '{4'hf, 8'hca}};
  always #2 clk = ~clk;
  stcd_host i_stcd_host (.clk(clk), .busy(busy), .wr_valid(wr_valid),
    .wr(wr));
  stcd_decoder #(.BIT_CYCLES(BC), .LOCKOUT(3)) i_stcd_decoder (
    .clk(clk), .rst_b(rst_b), .wr_valid(wr_valid), .wr(wr),
    .temp_index(8'h41), .measured_bit_period(8'h37),
    .memory_test_byte(8'h9d), .readback_byte(readback_byte),
    .readback_valid(readback_valid), .analog_drive(analog_drive),
    .analog_node_select(node), .busy(busy),
    .calibration_config(cal[0]), .offset_trim_dac(cal[1]),
    .offset_tempco_dac(cal[2]), .span_trim_dac(cal[3]),
    .span_tempco_dac(cal[4]));
  task automatic summarize;
    $display("Checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  always @(posedge clk)
  begin
    cyc++;
    if (analog_drive === 1'b1)
      drv++;
    // Ceiling well above the roughly 1400 cycles the tests need
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic put(input logic [3:0] f, input logic [3:0] n);
    i_stcd_host.put(f, n);
  endtask : put
  task automatic word(input logic [15:0] d);
    for (int i = 0; i < 4; i++)
      put(4'(i), d[4*i +: 4]);
  endtask : word
  task automatic rb(input logic [3:0] p);
    put(4'h8, p);
    put(4'h9, 4'h5);
    repeat (4)
      if (readback_valid !== 1'b1)
      begin
        @(posedge clk);
        #1;
      end
    b = (readback_valid === 1'b1) ? readback_byte : 8'hxx;
  endtask : rb
  initial
  begin
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge clk);
    word(16'hb7e4);
    put(4'h6, 4'h3);
    put(4'h7, 4'h9);
    put(4'ha, 4'h2);
    put(4'hb, 4'hc);
    foreach (rows[i])
    begin
      rb(rows[i].ptr);
      check("readback", 16'(b), 16'(rows[i].exp));
    end
    $display("Test readback table done");
    for (int i = 0; i < 5; i++)
    begin
      word(16'h1c3a + 16'(i) * 16'h1111);
      put(4'h6, 4'(i));
      put(4'h9, 4'h0);
    end
    put(4'h6, 4'h1);
    word(16'h5a5a);
    put(4'h9, 4'h8);
    for (int i = 0; i < 5; i++)
      check("cal_bank", cal[i], 16'h1c3a + 16'(i) * 16'h1111);
    word(16'h0000);
    put(4'h6, 4'h2);
    put(4'h9, 4'h3);
    rb(4'h0);
    check("read_cal_lo", {8'h00, b}, 16'h005c);
    rb(4'h1);
    check("read_cal_hi", {8'h00, b}, 16'h003e);
    $display("Test calibration bank done");
    put(4'h6, 4'h5);
    put(4'h7, 4'ha);
    for (int e = 0; e < 3; e++)
    begin
      // Pointer 6 puts address bits 9:8 at 2, byte 0x2a5 in page 10
      ev = (e == 0) ? 16'h00c7 : 16'h00ff;
      word(16'h00c7);
      put(4'h8, 4'h6);
      put(4'h9, 4'h1);
      if (e > 0)
        put(4'h9, (e == 1) ? 4'h7 : 4'h2);
      word(16'h0000);
      put(4'h8, 4'h6);
      put(4'h9, 4'h4);
      rb(4'h0);
      check("nvm_byte", {8'h00, b}, ev);
      rb(4'h6);
      check("nvm_data", {8'h00, b}, ev);
    end
    $display("Test nvm done");
    put(4'ha, 4'h1);
    put(4'hb, 4'h6);
    put(4'h9, 4'h6);
    drv = 0;
    i_stcd_host.put(4'h0, 4'h0, 1'b0);
    repeat (100) @(posedge clk);
    check("drive_cycles", 16'(drv), 16'(3 * 8 * BC));
    check("node", {12'h000, node}, 16'h0006);
    rb(4'h0);
    check("intrusion", {8'h00, b}, 16'h00ff);
    put(4'ha, 4'h0);
    drv = 0;
    put(4'h9, 4'h6);
    repeat (40) @(posedge clk);
    check("drive_short", 16'(drv), 16'(2 * 8 * BC));
    put(4'ha, 4'hf);
    put(4'h9, 4'h6);
    repeat (80) @(posedge clk);
    #1;
    check("forever_drive", {15'h0000, analog_drive}, 16'h0001);
    check("lockout_end", {15'h0000, busy}, 16'h0000);
    $display("Test analog probe done");
    rst_b = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("reset_drive", {15'h0000, analog_drive}, 16'h0000);
    check("reset_cal", cal[1], 16'h0000);
    rst_b = 1'b1;
    $display("Test reset done");
    summarize();
  end
endmodule : testbench
